// ===== rtl/vr_serial_vid_link_config_regs.sv
// configuration and identification bank of the regulator controller
// Summary of operation
// - reserved bits ignore writes, read zero
// - shed level is bits 8:4, 1A/step
// - add hysteresis is bits 3:0, 1A/step
// - level times phase count; DCM single phase fixed 5A
// - serial vout, max-output and state commands held off after enable rise delay
// - version bytes zero high nibble, nibble fields
// - state three exit latency in 15:8
// - state four exit latency in 7:0
// - vendor in 15:8, product in 7:0
// - project code and revision are read/write
// - bit 15 rejects max-output below present VID
// - bits 14/13 ack state cmds during DVID
// - bit 12 mirrors nvm write state
// - decay field picks fast, slow or normal
// - bits 9:8 seed multi-regulator config init
// - eight-bit telemetry support mask
// - fast slew 15:8, tolerance 7:0
// - PMBus over limit acks and clamps
// - serial over limit rejects, keeps target
// - tier two 15:8, tier one 7:0, 1A
// - max input power reads half the scale
`timescale 1ns/10ps
`default_nettype none
module vr_serial_vid_link_config_regs
  import vr_cfg_pkg::*;
#(
  // arbitrary neutral identity reset, not a real code
  parameter logic [15:0] IDENT_RESET = 16'h5A01,
  parameter int CYC_US = CYC_PER_US
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_write,
  input wire logic cmd_read,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic cmd_nak,
  input wire phase_in_t phase_in,
  output logic shed_phase,
  output logic add_phase,
  input wire logic enable,
  output logic cmd_ready,
  input wire logic state_three_exit_req,
  input wire logic state_four_exit_req,
  output logic state_three_exit_done,
  output logic state_four_exit_done,
  input wire vout_req_t vout_req,
  output logic [8:0] vout_target,
  input wire logic max_output_write_cmd,
  input wire logic [7:0] max_output_payload,
  input wire logic [7:0] present_vid,
  input wire logic set_state_four_cmd,
  input wire logic set_state_zero_cmd,
  input wire logic dvid_active,
  output resp_t resp,
  input wire logic decay_cmd,
  output decay_mode_t decay_mode,
  input wire logic [7:0] nvm_write_state,
  output view_t view
);

  typedef struct packed {
    logic [NREG-1:0][15:0] regs;
    logic [15:0] rdata;
    logic rvalid;
    logic nak;
    logic shed;
    logic add;
    logic en_q;
    logic [2:0][TMR_W-1:0] cnt;
    logic [2:0] busy;
    logic [2:0] done;
    logic [8:0] vout_target;
    resp_t resp;
    decay_mode_t decay;
    view_t view;
  } st_t;

  st_t s;
  st_t next_s;

  // slot lookup shared by read and write paths
  function automatic logic [4:0] decode(input logic [7:0] code);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < NREG; i++) begin
      if (CMD_TABLE[i] == code) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // exponent/mantissa sixteenths of a microsecond to cycles, rounded up
  function automatic logic [TMR_W-1:0] lat_cycles(
    input logic [7:0] f
  );
    logic [31:0] t;
    t = 32'(f[3:0]) << f[7:4];
    t = t * 32'(CYC_US);
    t = (t + 32'h0000000F) >> 4;
    return t[TMR_W-1:0];
  endfunction

  logic [4:0] wdec;
  logic [4:0] rdec;
  logic [12:0] shed_level;
  logic [13:0] add_level;
  logic [2:0] start;
  logic [2:0][TMR_W-1:0] lat;
  logic [NREG-1:0][15:0] r;

  assign r = s.regs;
  assign wdec = decode(cmd_code);
  assign rdec = decode(cmd_code);

  always_comb begin
    // DCM single phase ignores the programmed level
    if (phase_in.dcm && phase_in.phase_count == 3'h1) begin
      shed_level = {3'h0, DCM_SHED_A};
    end else begin
      // widen both factors first so the product keeps its top bits
      shed_level = 13'(r[S_SHED][LVL_HI:LVL_LO])
                   * 13'(phase_in.phase_count);
    end
    add_level = {1'b0, shed_level}
              + 14'(r[S_SHED][HYS_HI:0]);
  end

  assign start[0] = enable && !s.en_q;
  assign start[1] = state_three_exit_req;
  assign start[2] = state_four_exit_req;
  assign lat[0] = lat_cycles(r[S_PROTO][7:0]);
  assign lat[1] = lat_cycles(r[S_EXIT][15:BYTE_HI]);
  assign lat[2] = lat_cycles(r[S_EXIT][7:0]);

  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.nak = 1'b0;
    next_s.resp = '0;
    next_s.en_q = enable;
    // register port: write wins if both strobes arrive
    if (cmd_write) begin
      if (wdec[4]) begin
        next_s.regs[wdec[3:0]] = cmd_wdata
                                 & WMASK[wdec[3:0]];
      end else begin
        next_s.nak = 1'b1;
      end
    end else if (cmd_read) begin
      next_s.rvalid = 1'b1;
      if (rdec[4]) begin
        next_s.rdata = r[rdec[3:0]] & WMASK[rdec[3:0]];
      end else begin
        next_s.rdata = 16'h0000;
        next_s.nak = 1'b1;
      end
    end
    next_s.shed = {3'h0, phase_in.load_current}
                  < shed_level;
    next_s.add = {4'h0, phase_in.load_current}
                 > add_level;
    // enable-to-ready and low power exit timers
    for (int i = 0; i < 3; i++) begin
      if (start[i]) begin
        next_s.cnt[i] = lat[i];
        next_s.busy[i] = 1'b1;
        next_s.done[i] = 1'b0;
      end else if (s.busy[i]) begin
        if (s.cnt[i] <= TMR_W'(1)) begin
          next_s.busy[i] = 1'b0;
          next_s.done[i] = 1'b1;
        end else begin
          next_s.cnt[i] = s.cnt[i] - TMR_W'(1);
        end
      end
    end
    // dropping enable withdraws readiness on the next clock edge
    if (!enable) begin
      next_s.busy[0] = 1'b0;
      next_s.done[0] = 1'b0;
    end
    if (vout_req.req) begin
      if (vout_req.from_pmbus) begin
        next_s.resp.vout_ack = 1'b1;
        if (vout_req.code > r[S_VMAX][8:0]) begin
          next_s.vout_target = r[S_VMAX][8:0];
        end else begin
          next_s.vout_target = vout_req.code;
        end
      end else if (!s.done[0]
                   || vout_req.code > r[S_VMAX][8:0]) begin
        next_s.resp.vout_nak = 1'b1;
      end else begin
        next_s.resp.vout_ack = 1'b1;
        next_s.vout_target = vout_req.code;
      end
    end
    if (max_output_write_cmd) begin
      if (!s.done[0] || (r[S_DECAY][REJ_BIT]
          && max_output_payload < present_vid)) begin
        next_s.resp.maxout_nak = 1'b1;
      end else begin
        next_s.resp.maxout_ack = 1'b1;
      end
    end
    if (set_state_four_cmd || set_state_zero_cmd) begin
      if (s.done[0] && (!dvid_active
          || (set_state_four_cmd && r[S_DECAY][ACK4_BIT])
          || (set_state_zero_cmd && r[S_DECAY][ACK0_BIT]))) begin
        next_s.resp.ps_ack = 1'b1;
      end else begin
        next_s.resp.ps_nak = 1'b1;
      end
    end
    if (decay_cmd) begin
      unique case (r[S_DECAY][DEC_LO+1:DEC_LO])
        2'b01: next_s.decay = DECAY_FAST;
        2'b10: next_s.decay = DECAY_SLOW;
        2'b00, 2'b11: next_s.decay = DECAY_NORMAL;
      endcase
    end
    next_s.view.protocol_version_nibble =
      {4'h0, r[S_PROTO][PV1_LO+3:PV1_LO]};
    next_s.view.second_rail_version_nibble =
      {4'h0, r[S_PROTO][PV2_LO+3:PV2_LO]};
    next_s.view.vendor_identifier =
      r[S_IDENT][15:BYTE_HI];
    next_s.view.product_identifier = r[S_IDENT][7:0];
    next_s.view.project_code = r[S_PROJ];
    next_s.view.code_revision_value = r[S_REV][7:0];
    next_s.view.multi_regulator_config_init =
      r[S_DECAY][MVR_LO+1:MVR_LO];
    next_s.view.telemetry_support_mask =
      r[S_DECAY][7:0];
    next_s.view.fast_slew_capability =
      r[S_TOL][15:BYTE_HI];
    next_s.view.output_tolerance = r[S_TOL][7:0];
    next_s.view.tier_two_current_default =
      r[S_TIER][15:BYTE_HI];
    next_s.view.tier_one_current_default =
      r[S_TIER][7:0];
    next_s.view.tier_three_current_default = r[S_PIN][7:0];
    next_s.view.input_power_max_report =
      {1'b0, r[S_PIN][15:BYTE_HI+1]};
    // debug mirror stays quiet unless asked for
    next_s.view.nvm_write_state_mirror =
      r[S_DECAY][NVM_BIT] ? nvm_write_state : 8'h00;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      for (int i = 0; i < NREG; i++) begin
        s.regs[i] <= RESET_VAL;
      end
      s.regs[S_IDENT] <= IDENT_RESET;
      s.decay <= DECAY_NORMAL;
    end else begin
      s <= next_s;
    end
  end

  assign cmd_rdata = s.rdata;
  assign cmd_rvalid = s.rvalid;
  assign cmd_nak = s.nak;
  assign shed_phase = s.shed;
  assign add_phase = s.add;
  assign cmd_ready = s.done[0];
  assign state_three_exit_done = s.done[1];
  assign state_four_exit_done = s.done[2];
  assign vout_target = s.vout_target;
  assign resp = s.resp;
  assign decay_mode = s.decay;
  assign view = s.view;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // only a latency of two or more cycles leaves a low window to check
  sequence en_rise_s;
    enable && !s.en_q && lat[0] > TMR_W'(1);
  endsequence

  sequence shed_read_s;
    cmd_read && !cmd_write && cmd_code == CMD_TABLE[S_SHED];
  endsequence

  sequence pm_over_s;
    vout_req.req && vout_req.from_pmbus
      && vout_req.code > r[S_VMAX][8:0];
  endsequence

  sequence sv_over_s;
    vout_req.req && !vout_req.from_pmbus
      && vout_req.code > r[S_VMAX][8:0];
  endsequence

  rsv_read_a: assert property (
    shed_read_s |=> cmd_rvalid && cmd_rdata[15:9] == 7'h00)
    else $error("reserved bits read nonzero");

  ready_hold_a: assert property (
    en_rise_s |=> !cmd_ready [*2])
    else $error("ready came too early after enable");

  pm_clamp_a: assert property (
    pm_over_s |=> resp.vout_ack
      && vout_target == $past(r[S_VMAX][8:0]))
    else $error("pmbus over limit not clamped");

  sv_reject_a: assert property (
    sv_over_s |=> resp.vout_nak && !resp.vout_ack
      && $stable(vout_target))
    else $error("serial over limit not rejected");

  maxout_rej_a: assert property (
    max_output_write_cmd && r[S_DECAY][REJ_BIT]
      && max_output_payload < present_vid
      |=> resp.maxout_nak && !resp.maxout_ack)
    else $error("low max output accepted");

  ps_dvid_a: assert property (
    set_state_four_cmd && !set_state_zero_cmd && dvid_active
      && !r[S_DECAY][ACK4_BIT] |=> resp.ps_nak)
    else $error("state four acked during dvid");

  mirror_off_a: assert property (
    !r[S_DECAY][NVM_BIT] |=> view.nvm_write_state_mirror == 8'h00)
    else $error("nvm mirror leaked");

  version_hi_a: assert property (
    ##1 view.protocol_version_nibble[7:4] == 4'h0
      && view.protocol_version_nibble[3:0]
         == $past(r[S_PROTO][11:8]))
    else $error("version byte wrong");

  pin_half_a: assert property (
    ##1 view.input_power_max_report
        == ($past(r[S_PIN][15:8]) >> 1))
    else $error("max input power not half");

  shed_cmp_a: assert property (
    {3'h0, phase_in.load_current} < shed_level
      |=> shed_phase && !add_phase)
    else $error("shed not raised below level");

  decay_fast_a: assert property (
    decay_cmd && r[S_DECAY][11:10] == 2'b01
      |=> decay_mode == DECAY_FAST)
    else $error("fast decay not selected");

  decay_slow_a: assert property (
    decay_cmd && r[S_DECAY][DEC_LO+1:DEC_LO] == 2'b10
      |=> decay_mode == DECAY_SLOW)
    else $error("slow decay not selected");

  add_cmp_a: assert property (
    {4'h0, phase_in.load_current} > add_level
      |=> add_phase && !shed_phase)
    else $error("add not raised above level");

  mirror_on_a: assert property (
    r[S_DECAY][NVM_BIT]
      |=> view.nvm_write_state_mirror == $past(nvm_write_state))
    else $error("nvm mirror not shown");

  unmapped_nak_a: assert property (
    (cmd_write || cmd_read) && !wdec[4] |=> cmd_nak)
    else $error("unmapped code not refused");

  ready_drop_a: assert property (
    !enable |=> !cmd_ready)
    else $error("ready kept without enable");

endmodule
`default_nettype wire

// ===== rtl/vr_cfg_pkg.sv
// constants and carrier types of the regulator configuration bank
package vr_cfg_pkg;
  localparam int NREG = 11;
  // slot order of the bank
  localparam int S_SHED = 0;
  localparam int S_PROTO = 1;
  localparam int S_EXIT = 2;
  localparam int S_IDENT = 3;
  localparam int S_PROJ = 4;
  localparam int S_REV = 5;
  localparam int S_DECAY = 6;
  localparam int S_TOL = 7;
  localparam int S_VMAX = 8;
  localparam int S_TIER = 9;
  localparam int S_PIN = 10;
  localparam logic [NREG-1:0][7:0] CMD_TABLE = {
    8'hC6, 8'hC5, 8'hC4, 8'hC3, 8'hC2, 8'hC1,
    8'hC0, 8'hBF, 8'hBE, 8'hBD, 8'hBB};
  localparam logic [NREG-1:0][15:0] WMASK = {
    16'hFFFF, 16'hFFFF, 16'h01FF, 16'hFFFF, 16'hFFFF, 16'h00FF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h01FF};
  localparam logic [15:0] RESET_VAL = 16'h0000;
  // field positions
  localparam int LVL_HI = 8;
  localparam int LVL_LO = 4;
  localparam int HYS_HI = 3;
  localparam int PV2_LO = 12;
  localparam int PV1_LO = 8;
  localparam int BYTE_HI = 8;
  localparam int REJ_BIT = 15;
  localparam int ACK4_BIT = 14;
  localparam int ACK0_BIT = 13;
  localparam int NVM_BIT = 12;
  localparam int DEC_LO = 10;
  localparam int MVR_LO = 8;
  localparam logic [9:0] DCM_SHED_A = 10'h005;
  // timing
  localparam int US_NS = 1000;
  localparam int CLK_NS = 10;
  localparam int CYC_PER_US = US_NS / CLK_NS;
  localparam int TMR_W = 24;

  typedef enum logic [1:0] {
    DECAY_NORMAL = 2'b00,
    DECAY_FAST = 2'b01,
    DECAY_SLOW = 2'b10
  } decay_mode_t;

  typedef struct packed {
    logic [9:0] load_current;
    logic [2:0] phase_count;
    logic dcm;
  } phase_in_t;

  typedef struct packed {
    logic req;
    logic from_pmbus;
    logic [8:0] code;
  } vout_req_t;

  typedef struct packed {
    logic vout_ack;
    logic vout_nak;
    logic maxout_ack;
    logic maxout_nak;
    logic ps_ack;
    logic ps_nak;
  } resp_t;

  typedef struct packed {
    logic [7:0] protocol_version_nibble;
    logic [7:0] second_rail_version_nibble;
    logic [7:0] vendor_identifier;
    logic [7:0] product_identifier;
    logic [15:0] project_code;
    logic [7:0] code_revision_value;
    logic [1:0] multi_regulator_config_init;
    logic [7:0] telemetry_support_mask;
    logic [7:0] fast_slew_capability;
    logic [7:0] output_tolerance;
    logic [7:0] tier_one_current_default;
    logic [7:0] tier_two_current_default;
    logic [7:0] tier_three_current_default;
    logic [7:0] input_power_max_report;
    logic [7:0] nvm_write_state_mirror;
  } view_t;
endpackage

// ===== verif/vr_host_model.sv
// host model driving the command port of the configuration bank
`timescale 1ns/10ps
`default_nettype none
module vr_host_model (
  output logic [7:0] cmd_code,
  output logic cmd_write,
  output logic cmd_read,
  output logic [15:0] cmd_wdata,
  input wire logic clk,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic cmd_nak
);
  initial begin
    cmd_code = 8'h00;
    cmd_write = 1'b0;
    cmd_read = 1'b0;
    cmd_wdata = 16'h0000;
  end
  // data scrambled once released so a stale word never reads as valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    cmd_code <= a;
    cmd_wdata <= d;
    cmd_write <= 1'b1;
    @(posedge clk);
    cmd_write <= 1'b0;
    cmd_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic [1:0] st);
    @(posedge clk);
    cmd_code <= a;
    cmd_read <= 1'b1;
    @(posedge clk);
    cmd_read <= 1'b0;
    @(negedge clk);
    d = cmd_rdata;
    st = {cmd_rvalid, cmd_nak};
  endtask
endmodule
`default_nettype wire

// ===== verif/vr_serial_vid_link_config_regs_test.sv
// self-checking bench of the regulator configuration bank
`timescale 1ns/10ps
`default_nettype none
module vr_serial_vid_link_config_regs_test
  import vr_cfg_pkg::*;
;
  // arbitrary identity reset, not a real code
  localparam logic [15:0] IDENT = 16'h6C02;
  logic clk, rst, cmd_write, cmd_read, cmd_rvalid, cmd_nak, shed_phase;
  logic add_phase, enable, cmd_ready, s3_req, s4_req, s3_done, s4_done;
  logic max_cmd, ps4_cmd, ps0_cmd, dvid, decay_cmd;
  logic [7:0] cmd_code, max_pl, pvid, nvm;
  logic [15:0] cmd_wdata, cmd_rdata, d;
  logic [8:0] vout_target;
  logic [1:0] st;
  phase_in_t phase_in;
  vout_req_t vout_req;
  resp_t resp;
  decay_mode_t decay_mode;
  view_t view;
  int miscompares, samples_checked, n;
  logic [7:0] adr [11] = '{8'hBB, 8'hBD, 8'hBE, 8'hBF, 8'hC0, 8'hC1,
    8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6};
  logic [15:0] pat [11] = '{16'hFE32, 16'hA524, 16'h2838, 16'h1234,
    16'hBE5A, 16'hFF96, 16'h03C7, 16'h2A14, 16'hFF00, 16'h3C1E, 16'h9A50};

  // short timer unit keeps the delay scenarios brief
  vr_serial_vid_link_config_regs #(.IDENT_RESET(IDENT), .CYC_US(2)) u_dut (
    .clk, .rst, .cmd_code, .cmd_write, .cmd_read, .cmd_wdata,
    .cmd_rdata, .cmd_rvalid, .cmd_nak, .phase_in, .shed_phase,
    .add_phase, .enable, .cmd_ready, .state_three_exit_req(s3_req),
    .state_four_exit_req(s4_req), .state_three_exit_done(s3_done),
    .state_four_exit_done(s4_done), .vout_req, .vout_target,
    .max_output_write_cmd(max_cmd), .max_output_payload(max_pl),
    .present_vid(pvid), .set_state_four_cmd(ps4_cmd),
    .set_state_zero_cmd(ps0_cmd), .dvid_active(dvid), .resp,
    .decay_cmd, .decay_mode, .nvm_write_state(nvm), .view);
  vr_host_model u_host (.clk, .cmd_code, .cmd_write, .cmd_read,
    .cmd_wdata, .cmd_rdata, .cmd_rvalid, .cmd_nak);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [15:0] ex(input logic [7:0] a,
                                     input logic [15:0] v);
    if (a == 8'hBB || a == 8'hC4) return v & 16'h01FF;
    if (a == 8'hC1) return v & 16'h00FF;
    return v;
  endfunction

  function automatic logic pick(input int w);
    return w == 0 ? cmd_ready : (w == 1 ? s3_done : s4_done);
  endfunction

  task automatic t_regs;
    foreach (adr[i]) begin
      u_host.rd(adr[i], d, st);
      chk(d, adr[i] == 8'hBF ? IDENT : 16'h0000);
      chk(16'(st), 16'h0002);
    end
    foreach (adr[i]) u_host.wr(adr[i], pat[i]);
    foreach (adr[i]) begin
      u_host.rd(adr[i], d, st);
      chk(d, ex(adr[i], pat[i]));
    end
    u_host.wr(8'hBC, 16'hFFFF);
    @(negedge clk);
    chk(16'(cmd_nak), 16'h0001);
    u_host.rd(8'hBC, d, st);
    chk(d, 16'h0000);
    chk(16'(st), 16'h0003);
    chk(16'(view.protocol_version_nibble), 16'h0005);
    chk(16'(view.second_rail_version_nibble), 16'h000A);
    chk({view.vendor_identifier, view.product_identifier}, 16'h1234);
    chk(view.project_code, 16'hBE5A);
    chk(16'(view.code_revision_value), 16'h0096);
    chk(16'({view.multi_regulator_config_init,
      view.telemetry_support_mask}), 16'h03C7);
    chk({view.fast_slew_capability,
      view.output_tolerance}, 16'h2A14);
    chk({view.tier_two_current_default,
      view.tier_one_current_default}, 16'h3C1E);
    chk({view.input_power_max_report,
      view.tier_three_current_default}, 16'h4D50);
    $display("test registers done");
  endtask

  task automatic sh(input logic [9:0] ld, input logic [2:0] pc,
                    input logic dcm, input logic [1:0] e);
    @(posedge clk);
    phase_in <= '{ld, pc, dcm};
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(16'({shed_phase, add_phase}), 16'(e));
  endtask

  // counts low samples of a done flag from the launching edge onward
  task automatic tm(input int w, input int exp);
    @(posedge clk);
    if (w == 0) enable <= 1'b1;
    if (w == 1) s3_req <= 1'b1;
    if (w == 2) s4_req <= 1'b1;
    n = 0;
    repeat (30) begin
      @(negedge clk);
      if (pick(w) !== 1'b1) n++;
      @(posedge clk);
      s3_req <= 1'b0;
      s4_req <= 1'b0;
    end
    chk(16'(n), 16'(exp));
  endtask

  task automatic vq(input logic pm, input logic [8:0] c,
                    input logic [1:0] e, input logic [8:0] t);
    @(posedge clk);
    vout_req <= '{1'b1, pm, c};
    @(posedge clk);
    vout_req.req <= 1'b0;
    @(negedge clk);
    chk(16'({resp.vout_ack, resp.vout_nak}), 16'(e));
    chk(16'(vout_target), 16'(t));
  endtask

  task automatic mq(input logic [7:0] p, input logic [1:0] e);
    @(posedge clk);
    max_cmd <= 1'b1;
    max_pl <= p;
    @(posedge clk);
    max_cmd <= 1'b0;
    @(negedge clk);
    chk(16'({resp.maxout_ack, resp.maxout_nak}), 16'(e));
  endtask

  task automatic pq(input logic four, input logic [1:0] e);
    @(posedge clk);
    if (four) ps4_cmd <= 1'b1;
    else ps0_cmd <= 1'b1;
    @(posedge clk);
    ps4_cmd <= 1'b0;
    ps0_cmd <= 1'b0;
    @(negedge clk);
    chk(16'({resp.ps_ack, resp.ps_nak}), 16'(e));
  endtask

  task automatic t_misc;
    sh(10'd5, 3'd2, 1'b0, 2'b10);
    sh(10'd8, 3'd2, 1'b0, 2'b00);
    sh(10'd9, 3'd2, 1'b0, 2'b01);
    sh(10'd8, 3'd3, 1'b0, 2'b10);
    sh(10'd4, 3'd1, 1'b1, 2'b10);
    sh(10'd5, 3'd1, 1'b1, 2'b00);
    vq(1'b0, 9'h010, 2'b01, 9'h000);
    tm(0, 3);
    vq(1'b0, 9'h120, 2'b01, 9'h000);
    vq(1'b0, 9'h080, 2'b10, 9'h080);
    vq(1'b0, 9'h120, 2'b01, 9'h080);
    vq(1'b1, 9'h150, 2'b10, 9'h100);
    tm(1, 5);
    tm(2, 9);
    $display("test timing and limits done");
  endtask

  task automatic t_cfg;
    u_host.wr(8'hC2, 16'h83C7);
    mq(8'h40, 2'b01);
    mq(8'h50, 2'b10);
    u_host.wr(8'hC2, 16'h03C7);
    mq(8'h40, 2'b10);
    @(posedge clk);
    dvid <= 1'b1;
    pq(1'b1, 2'b01);
    u_host.wr(8'hC2, 16'h43C7);
    pq(1'b1, 2'b10);
    pq(1'b0, 2'b01);
    u_host.wr(8'hC2, 16'h23C7);
    pq(1'b0, 2'b10);
    chk(16'(view.nvm_write_state_mirror), 16'h0000);
    u_host.wr(8'hC2, 16'h13C7);
    repeat (3) @(negedge clk);
    chk(16'(view.nvm_write_state_mirror), 16'h005A);
    for (int i = 0; i < 4; i++) begin
      u_host.wr(8'hC2, {4'h0, 2'(i), 10'h3C7});
      @(posedge clk);
      decay_cmd <= 1'b1;
      @(posedge clk);
      decay_cmd <= 1'b0;
      @(negedge clk);
      chk(16'(decay_mode), i == 3 ? 16'h0000 : 16'(i));
    end
    $display("test capability options done");
  endtask

  initial begin
    rst = 1'b1;
    enable = 1'b0;
    s3_req = 1'b0;
    s4_req = 1'b0;
    max_cmd = 1'b0;
    ps4_cmd = 1'b0;
    ps0_cmd = 1'b0;
    dvid = 1'b0;
    decay_cmd = 1'b0;
    max_pl = 8'h00;
    pvid = 8'h50;
    nvm = 8'h5A;
    phase_in = '0;
    vout_req = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_misc;
    t_cfg;
    report_and_stop;
  end

  // whole run needs well under a thousand cycles
  initial begin
    #200000;
    miscompares++;
    report_and_stop;
  end
endmodule
`default_nettype wire
